/* File: common/dbp_pkg.sv */
// Constants, types and helpers of the data-space paging and NVM block.
// Assumes an 8-bit data space and a 12-bit program address.
package dbp_pkg;

    // Data-space map of the block
    localparam logic [7:0] DBP_WIN_LO = 8'h40;
    localparam logic [7:0] DBP_WIN_HI = 8'h7F;
    localparam logic [7:0] DBP_BANK_HI = 8'h3F;
    localparam logic [7:0] DBP_ADDR_WIN_BASE = 8'hC9;
    localparam logic [7:0] DBP_ADDR_BANK_SEL = 8'hCB;
    localparam logic [7:0] DBP_ADDR_NVM_CTL = 8'hDF;

    // Bank select bit positions
    localparam int DBP_BNK_NVM0 = 0;
    localparam int DBP_BNK_NVM1 = 1;
    localparam int DBP_BNK_RAM2 = 4;

    // NVM control bit positions
    localparam int DBP_CTL_WEN = 0;
    localparam int DBP_CTL_BUSY = 1;
    localparam int DBP_CTL_ROW = 2;
    localparam int DBP_CTL_START = 3;
    localparam int DBP_CTL_STBY = 6;
    localparam logic DBP_CTL_RST = 1'b0;

    // Geometry
    localparam int DBP_WIN_BITS = 6;
    localparam int DBP_PM_AW = 12;
    localparam int DBP_ROW_BYTES = 8;
    localparam int DBP_NVM_DEPTH = 128;
    localparam int DBP_PAGE_DEPTH = 64;

    // Programming cycle: time in microseconds, clock in MHz
    localparam int DBP_PROG_TIME_US = 10;
    localparam int DBP_CLK_MHZ = 200;
    localparam int DBP_PROG_CYC = DBP_PROG_TIME_US * DBP_CLK_MHZ;
    localparam int DBP_CNT_W = 16;

    // NVM write sequencer states
    typedef enum logic [1:0]
    {
        DBP_IDLE = 2'b00,
        DBP_ROWFILL = 2'b01,
        DBP_PROG = 2'b10
    } dbp_nvm_st_t;

    // Address lies in the program-memory window
    function automatic logic dbp_in_window(input logic [7:0] a);
        dbp_in_window = (a >= DBP_WIN_LO) && (a <= DBP_WIN_HI);
    endfunction : dbp_in_window

    // Address lies in the banked region
    function automatic logic dbp_in_bank(input logic [7:0] a);
        dbp_in_bank = (a <= DBP_BANK_HI);
    endfunction : dbp_in_bank

endpackage : dbp_pkg

/* File: common/dbp_nvm_if.sv */
// Link between the paging controller and the NVM cell array.
// Assumes both ends share one clock; the interface carries no state.
`timescale 1ns/1ps
interface dbp_nvm_if;
    logic [6:0] raddr; // Read address, page bit above offset
    logic [7:0] rdata; // Cell contents at raddr
    logic go; // One-cycle commit of the row latches
    logic [3:0] row; // Row being committed
    logic [7:0] mask; // Bytes of the row to commit
    logic [63:0] data; // Row latch contents, byte 0 lowest

    modport ctrl (output raddr, output go, output row, output mask,
                  output data, input rdata);
    modport array (input raddr, input go, input row, input mask,
                   input data, output rdata);
endinterface : dbp_nvm_if

/* File: design/dbp_prog_timer.sv */
// Programming-cycle timer of the NVM block.
// Assumes start_i is a one-cycle pulse given only while idle.
`timescale 1ns/1ps
module dbp_prog_timer #(
    parameter int PROG_CYC = dbp_pkg::DBP_PROG_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);
    import dbp_pkg::*;

    logic [DBP_CNT_W-1:0] cnt_r; // Cycles left in the current cycle

    // Load on start, then count down to zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_r <= '0;
        else if (start_i)
            cnt_r <= DBP_CNT_W'(PROG_CYC);
        else if (cnt_r != '0)
            cnt_r <= cnt_r - 1'b1;
    end

    // Busy lasts exactly PROG_CYC cycles; done marks the last of them
    assign busy_o = (cnt_r != '0);
    assign done_o = (cnt_r == DBP_CNT_W'(1));
endmodule : dbp_prog_timer

/* File: design/dbp_nvm_array.sv */
// Nonvolatile cell array: two 64-byte pages, written a row at a time.
// Assumes the controller gives go only at the end of a busy cycle.
`timescale 1ns/1ps
module dbp_nvm_array (
    input wire logic clk_i,
    dbp_nvm_if.array nv
);
    import dbp_pkg::*;

    logic [7:0] mem [DBP_NVM_DEPTH]; // Cells; reset must not touch them

    // Commit only the masked bytes; others in the row keep their value
    always_ff @(posedge clk_i)
    begin
        if (nv.go)
        begin
            for (int i = 0; i < DBP_ROW_BYTES; i++)
            begin
                if (nv.mask[i])
                    mem[{nv.row, 3'(i)}] <= nv.data[i*8 +: 8];
            end
        end
    end

    // Reads are combinational so they match RAM timing upstream
    assign nv.rdata = mem[nv.raddr];
endmodule : dbp_nvm_array

/* File: design/dbp_paging_ctrl.sv */
// Data-space paging, program-memory window and NVM write control.
// Assumes the core gives one read or write strobe per cycle, with
// address and data valid in that cycle, and program memory answers
// a window address combinationally in the same cycle.
//
// Contract
// - Window 40h-7Fh reads come from program memory
// - Window base forms upper program address bits
// - Window base is write-only, no readback
// - Window base not cleared by reset
// - Only window base bits 5-0 used
// - Bank codes: 01h,02h NVM pages, 10h RAM
// - Addresses 00h-3Fh go to selected bank
// - Bank register write-only, not reset
// - Bank register kept across interrupts and calls
// - NVM needs bank selected and standby clear
// - Programming needs write enable set first
// - Busy set for whole programming cycle
// - Idle NVM reads like RAM, same timing
// - Single-byte writes and 8-byte row writes
// - Control writes ignored while busy
// - Row mode locks row, blocks reads
// - Entering row mode clears row latches
// - Row mode bit clears at cycle end
// - Start bit needs enable and row mode
// - Write with enable clear starts nothing
// - Access while busy aborted, cycle finishes
`timescale 1ns/1ps
module dbp_paging_ctrl #(
    parameter int PROG_CYC = dbp_pkg::DBP_PROG_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] pm_rdata_i,
    output logic [dbp_pkg::DBP_PM_AW-1:0] pm_addr_o,
    output logic [7:0] rdata_o,
    output logic rd_hit_o,
    output logic nvm_busy_flag_o
);
    import dbp_pkg::*;

    // Write-only paging registers; deliberately without reset
    logic [DBP_WIN_BITS-1:0] window_base_bits_r; // Window base
    logic [7:0] data_bank_select_r; // Bank select

    // NVM control bits
    logic nvm_standby_r; // Array powered down
    logic nvm_write_enable_r; // Programming allowed
    logic row_mode_enable_r; // Row latches armed
    logic row_program_start_r; // Row cycle launched

    // Row latches
    logic [63:0] row_data_r; // Latched bytes
    logic [7:0] row_mask_r; // Bytes written since row mode set
    logic [3:0] row_addr_r; // Locked row
    logic row_locked_r; // Row address has been taken

    // Sequencer and RAM page
    dbp_nvm_st_t state_r; // Write sequencer state
    dbp_nvm_st_t state_nxt; // Next state
    logic [7:0] ram_page2 [DBP_PAGE_DEPTH]; // Extra RAM page

    // Read path registers
    logic [7:0] rdata_r; // Answer byte
    logic rd_hit_r; // Answer belongs to this block

    // Decode
    logic busy; // Programming in progress
    logic prog_done; // Last busy cycle
    logic launch; // Start a programming cycle
    logic in_win; // Window address
    logic in_bank; // Banked address
    logic nvm_sel; // An NVM page is selected
    logic nvm_ok; // NVM usable now
    logic [6:0] nvm_addr; // Page bit plus offset
    logic nvm_wr; // Accepted NVM data write
    logic ctl_wr; // Accepted control write
    logic row_set_ev; // Row mode being entered
    logic row_clr_ev; // Row mode dropped by software
    logic start_ev; // Valid row start request
    logic byte_ev; // Single-byte write launch
    logic row_wr_ev; // Byte loaded into row latch
    logic ram2_wr; // RAM page write

    dbp_nvm_if nv ();

    // Program-memory address: base above the low six address bits
    assign pm_addr_o = {window_base_bits_r, addr_i[5:0]};

    // Region decode
    assign in_win = dbp_in_window(addr_i);
    assign in_bank = dbp_in_bank(addr_i);
    assign nvm_sel = data_bank_select_r[DBP_BNK_NVM0] |
                     data_bank_select_r[DBP_BNK_NVM1];
    assign nvm_addr = {data_bank_select_r[DBP_BNK_NVM1], addr_i[5:0]};
    // Standby, no page or a running cycle make the array unusable
    assign nvm_ok = in_bank && nvm_sel && !nvm_standby_r &&
                    !busy && (state_r != DBP_PROG);

    // Data writes need the enable bit; without it nothing starts
    assign nvm_wr = wr_i && nvm_ok && nvm_write_enable_r;
    // Control register is frozen while a cycle runs
    assign ctl_wr = wr_i && (addr_i == DBP_ADDR_NVM_CTL) && !busy
                    && (state_r != DBP_PROG);
    assign row_set_ev = ctl_wr && wdata_i[DBP_CTL_ROW] &&
                        !row_mode_enable_r;
    assign row_clr_ev = ctl_wr && !wdata_i[DBP_CTL_ROW];
    // Start only with enable and row mode both set
    assign start_ev = ctl_wr && wdata_i[DBP_CTL_START] &&
                      wdata_i[DBP_CTL_WEN] && wdata_i[DBP_CTL_ROW] &&
                      (state_r == DBP_ROWFILL);
    assign byte_ev = nvm_wr && (state_r == DBP_IDLE);
    // Only the locked row takes data; other rows are dropped
    assign row_wr_ev = nvm_wr && (state_r == DBP_ROWFILL) &&
                       (!row_locked_r ||
                        nvm_addr[6:3] == row_addr_r);
    assign launch = byte_ev || start_ev;
    assign ram2_wr = wr_i && in_bank &&
                     data_bank_select_r[DBP_BNK_RAM2];

    // Window base: loaded on write only, never reset, bits 7:6 dropped
    always_ff @(posedge clk_i)
    begin
        if (wr_i && addr_i == DBP_ADDR_WIN_BASE)
            window_base_bits_r <= wdata_i[DBP_WIN_BITS-1:0];
    end

    // Bank select: changes on its own write only, so calls and
    // interrupt entry leave it alone; reset leaves it as it was
    always_ff @(posedge clk_i)
    begin
        if (wr_i && addr_i == DBP_ADDR_BANK_SEL)
            data_bank_select_r <= wdata_i;
    end

    // Control bits; the end of a cycle drops row mode and start
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            nvm_standby_r <= DBP_CTL_RST;
            nvm_write_enable_r <= DBP_CTL_RST;
            row_mode_enable_r <= DBP_CTL_RST;
            row_program_start_r <= DBP_CTL_RST;
        end
        else if (prog_done)
        begin
            row_mode_enable_r <= 1'b0;
            row_program_start_r <= 1'b0;
        end
        else if (ctl_wr)
        begin
            nvm_standby_r <= wdata_i[DBP_CTL_STBY];
            nvm_write_enable_r <= wdata_i[DBP_CTL_WEN];
            row_mode_enable_r <= wdata_i[DBP_CTL_ROW];
            // A refused start leaves the bit as it was
            if (start_ev)
                row_program_start_r <= 1'b1;
        end
    end

    // Row latches: cleared on entering row mode, one byte per write;
    // a byte write reuses them with a single-byte mask
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            row_mask_r <= 8'h00;
            row_locked_r <= 1'b0;
            row_addr_r <= 4'h0;
            row_data_r <= '0;
        end
        else if (row_set_ev)
        begin
            row_mask_r <= 8'h00;
            row_locked_r <= 1'b0;
        end
        else if (byte_ev)
        begin
            row_mask_r <= 8'(1) << nvm_addr[2:0];
            row_addr_r <= nvm_addr[6:3];
            row_data_r[nvm_addr[2:0]*8 +: 8] <= wdata_i;
        end
        else if (row_wr_ev)
        begin
            row_mask_r[nvm_addr[2:0]] <= 1'b1;
            row_addr_r <= nvm_addr[6:3];
            row_locked_r <= 1'b1;
            row_data_r[nvm_addr[2:0]*8 +: 8] <= wdata_i;
        end
    end

    // Sequencer next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            DBP_IDLE:
            begin
                // Byte write starts at once; row mode waits for data
                if (byte_ev)
                    state_nxt = DBP_PROG;
                else if (row_set_ev)
                    state_nxt = DBP_ROWFILL;
            end
            DBP_ROWFILL:
            begin
                if (start_ev)
                    state_nxt = DBP_PROG;
                else if (row_clr_ev)
                    state_nxt = DBP_IDLE; // Latches abandoned
            end
            DBP_PROG:
            begin
                // Only reset aborts a running cycle
                if (prog_done)
                    state_nxt = DBP_IDLE;
            end
            default:
                state_nxt = DBP_IDLE;
        endcase
    end

    // Sequencer state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_r <= DBP_IDLE;
        else
            state_r <= state_nxt;
    end

    // RAM page storage; contents survive reset like ordinary RAM
    always_ff @(posedge clk_i)
    begin
        if (ram2_wr)
            ram_page2[addr_i[5:0]] <= wdata_i;
    end

    // Read answer, registered; the NVM and RAM page answers merge by OR, which
    // is why software must keep only one set
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_r <= 8'h00;
            rd_hit_r <= 1'b0;
        end
        else if (rd_i && in_win)
        begin
            rdata_r <= pm_rdata_i;
            rd_hit_r <= 1'b1;
        end
        else if (rd_i && in_bank && (nvm_sel ||
                 data_bank_select_r[DBP_BNK_RAM2]))
        begin
            // NVM reads blocked in row mode and while unusable
            rdata_r <= ((nvm_ok && state_r == DBP_IDLE) ?
                        nv.rdata : 8'h00) |
                       (data_bank_select_r[DBP_BNK_RAM2] ?
                        ram_page2[addr_i[5:0]] : 8'h00);
            rd_hit_r <= 1'b1;
        end
        else if (rd_i && addr_i == DBP_ADDR_NVM_CTL)
        begin
            // Only the busy flag reads back; paging registers do not
            rdata_r <= 8'(busy) << DBP_CTL_BUSY;
            rd_hit_r <= 1'b1;
        end
        else
        begin
            rd_hit_r <= 1'b0;
        end
    end

    // Link to the array; commit happens on the last busy cycle
    assign nv.raddr = nvm_addr;
    assign nv.go = prog_done;
    assign nv.row = row_addr_r;
    assign nv.mask = row_mask_r;
    assign nv.data = row_data_r;

    dbp_prog_timer #(
        .PROG_CYC(PROG_CYC)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(launch),
        .busy_o(busy),
        .done_o(prog_done)
    );

    dbp_nvm_array u_array (
        .clk_i(clk_i),
        .nv(nv.array)
    );

    assign rdata_o = rdata_r;
    assign rd_hit_o = rd_hit_r;
    assign nvm_busy_flag_o = busy;

    // Helper: length of the current busy run
    logic [DBP_CNT_W-1:0] busy_run_r;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !busy)
            busy_run_r <= '0;
        else
            busy_run_r <= busy_run_r + 1'b1;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    win_base_load_a: assert property (
        wr_i && addr_i == DBP_ADDR_WIN_BASE
        |=> pm_addr_o[11:6] == $past(wdata_i[5:0]))
        else $error("window base not loaded from low six bits");

    win_read_a: assert property (
        rd_i && dbp_in_window(addr_i)
        |=> rd_hit_o && rdata_o == $past(pm_rdata_i))
        else $error("window read not from program memory");

    bank_hold_a: assert property (
        !(wr_i && addr_i == DBP_ADDR_BANK_SEL)
        |=> $stable(data_bank_select_r))
        else $error("bank select changed without a write");

    busy_freeze_a: assert property (
        busy && wr_i && addr_i == DBP_ADDR_NVM_CTL
        |=> $stable({nvm_standby_r, nvm_write_enable_r}))
        else $error("control changed while busy");

    no_enable_a: assert property (
        state_r == DBP_IDLE && !busy && wr_i && !nvm_write_enable_r
        |=> !busy)
        else $error("write without enable started a cycle");

    busy_length_a: assert property (
        $fell(busy) |-> busy_run_r == DBP_CNT_W'(PROG_CYC))
        else $error("busy run length wrong");

    row_clear_a: assert property (
        row_set_ev |=> row_mask_r == 8'h00 && !row_locked_r)
        else $error("row latches not cleared on row mode");

    start_gate_a: assert property (
        ctl_wr && wdata_i[DBP_CTL_START] && !start_ev
        |=> !busy && !row_program_start_r)
        else $error("start accepted without enable and row mode");

    row_end_a: assert property (
        prog_done |=> !row_mode_enable_r && state_r == DBP_IDLE)
        else $error("row mode not cleared at cycle end");

    nvm_read_a: assert property (
        rd_i && nvm_ok && state_r == DBP_IDLE &&
        !data_bank_select_r[DBP_BNK_RAM2]
        |=> rd_hit_o && rdata_o == $past(nv.rdata))
        else $error("idle NVM read wrong");
endmodule : dbp_paging_ctrl

/* File: sim/dbp_pm_model.sv */
// Program memory seen by the block: one byte for each program address.
// Assumes the block reads it combinationally in the access cycle.
`timescale 1ns/1ps
module dbp_pm_model (
    input wire logic [11:0] pm_addr_i, // Address formed by the block
    output logic [7:0] pm_rdata_o // Byte at that address
);
    // Contents follow the address, so a wrong upper bit shows up.
    // An unknown address gives unknown data, as a real store would.
    always_comb
    begin
        pm_rdata_o = pm_addr_i[7:0] ^ {pm_addr_i[11:8], 4'h5};
    end
endmodule : dbp_pm_model

/* File: sim/dbp_paging_ctrl_tb_top.sv */
// Self-checking bench: window, banks, mid-run reset, NVM byte/row writes.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/1ps
module dbp_paging_ctrl_tb_top;
    import dbp_pkg::*;
    localparam int PCYC = 12; // Short programming cycle keeps runs brief
    logic clk_i, rst_i, wr_i, rd_i, rd_hit, busy;
    logic [7:0] addr_i, wdata_i, pm_rdata, rdata;
    logic [11:0] pm_addr, last_pm; // Program address seen in a read
    int bad_count, samples_checked;
    int cyc = 0; // Cycles since time zero, for the hang guard
    dbp_paging_ctrl #(.PROG_CYC(PCYC)) i_dut (.clk_i(clk_i),
        .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .pm_rdata_i(pm_rdata), .pm_addr_o(pm_addr),
        .rdata_o(rdata), .rd_hit_o(rd_hit), .nvm_busy_flag_o(busy));
    dbp_pm_model i_pm (.pm_addr_i(pm_addr), .pm_rdata_o(pm_rdata));
    // Clock at 200 MHz
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Hang guard: far above the about 155 cycles the tests need
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            bad_count++;
            wrap_up();
        end
    end
    // Bench copy of the program memory contents
    function automatic logic [7:0] pm_exp(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'h5};
    endfunction : pm_exp
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask : tick
    task automatic chk(input logic [11:0] g, input logic [11:0] e);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // One write cycle; request held until the sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick();
        wr_i = 1'b1;
        addr_i = a;
        wdata_i = d;
        tick();
        wr_i = 1'b0;
        wdata_i = ~d; // Data no longer valid, so show something else
    endtask : wr
    // One read cycle; answer looked at in the cycle it stands
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input logic h);
        tick();
        rd_i = 1'b1;
        addr_i = a;
        #1 last_pm = pm_addr;
        tick();
        rd_i = 1'b0;
        chk(rd_hit, h);
        if (h)
            chk(rdata, e);
    endtask : rd
    // Waits out busy under a bound and checks its length
    task automatic wait_done();
        int n;
        n = 0;
        while (busy === 1'b1 && n < 1000)
        begin
            tick();
            n++;
        end
        chk(n, PCYC);
    endtask : wait_done
    task automatic t_window();
        wr(DBP_ADDR_WIN_BASE, 8'he8); // Base 28h, top bits must not count
        rd(8'h59, pm_exp(12'ha19), 1'b1);
        chk(last_pm, 12'ha19);
        rd(8'h40, pm_exp(12'ha00), 1'b1);
        rd(DBP_ADDR_WIN_BASE, 8'h00, 1'b0);
        rd(DBP_ADDR_BANK_SEL, 8'h00, 1'b0);
        // No bank selected: the banked region must not answer
        wr(DBP_ADDR_BANK_SEL, 8'h00);
        rd(8'h10, 8'h00, 1'b0);
    endtask : t_window
    // Window base and bank survive a reset in mid-run
    task automatic t_reset();
        wr(DBP_ADDR_BANK_SEL, 8'h10); // One bank bit only
        wr(8'h05, 8'ha5);
        rd(8'h05, 8'ha5, 1'b1);
        tick();
        rst_i = 1'b1;
        tick();
        tick();
        rst_i = 1'b0;
        chk(busy, 1'b0);
        rd(8'h05, 8'ha5, 1'b1);
        rd(8'h59, pm_exp(12'ha19), 1'b1);
    endtask : t_reset
    task automatic t_byte();
        wr(DBP_ADDR_BANK_SEL, 8'h01);
        wr(DBP_ADDR_NVM_CTL, 8'h00); // Bits 4,5 kept clear
        wr(8'h10, 8'h3c);
        chk(busy, 1'b0);
        wr(DBP_ADDR_NVM_CTL, 8'h01);
        wr(8'h10, 8'h3c);
        wait_done();
        rd(8'h10, 8'h3c, 1'b1);
        wr(DBP_ADDR_NVM_CTL, 8'h41);
        rd(8'h10, 8'h00, 1'b1);
        wr(8'h10, 8'h00);
        chk(busy, 1'b0);
        wr(DBP_ADDR_NVM_CTL, 8'h01);
        rd(8'h10, 8'h3c, 1'b1);
    endtask : t_byte
    // Page 1 write with control and NVM accesses during busy
    task automatic t_busy();
        wr(DBP_ADDR_BANK_SEL, 8'h02);
        wr(8'h10, 8'h5a);
        rd(DBP_ADDR_NVM_CTL, 8'h02, 1'b1);
        wr(DBP_ADDR_NVM_CTL, 8'h40);
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h00, 1'b1);
        while (busy === 1'b1 && cyc < 2900)
            tick();
        rd(8'h10, 8'h5a, 1'b1);
        wr(DBP_ADDR_BANK_SEL, 8'h01);
        rd(8'h10, 8'h3c, 1'b1);
    endtask : t_busy
    task automatic t_row();
        wr(8'h18, 8'h11);
        wait_done();
        wr(8'h19, 8'h77);
        wait_done();
        wr(DBP_ADDR_NVM_CTL, 8'h05);
        wr(8'h18, 8'hee);
        wr(DBP_ADDR_NVM_CTL, 8'h01); // Abandon the latches
        wr(DBP_ADDR_NVM_CTL, 8'h05);
        wr(8'h1a, 8'h22);
        wr(8'h10, 8'h99);
        chk(busy, 1'b0);
        rd(8'h19, 8'h00, 1'b1);
        wr(DBP_ADDR_NVM_CTL, 8'h0d);
        wait_done();
        rd(8'h18, 8'h11, 1'b1);
        rd(8'h19, 8'h77, 1'b1);
        rd(8'h1a, 8'h22, 1'b1);
        rd(8'h10, 8'h3c, 1'b1);
        wr(DBP_ADDR_NVM_CTL, 8'h09);
        chk(busy, 1'b0);
    endtask : t_row
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // Main sequence: reset for 8 cycles, then the scenarios
    initial
    begin
        bad_count = 0;
        samples_checked = 0;
        rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 8'hff;
        wdata_i = 8'h00;
        repeat (8) tick();
        rst_i = 1'b0;
        // No interrupt handlers here, so write-only registers need no image
        t_window();
        t_reset();
        t_byte();
        t_busy();
        t_row();
        wrap_up();
    end
endmodule : dbp_paging_ctrl_tb_top
